//--- zcs_zero_clamp_speed_control.sv
`timescale 1ns/10ps
// Notes on behaviour
// - With the clamp request inactive the clamp stays off and the speed reference is followed.
// - The clamp request pin is active low, a low level commands the clamp.
// - Clamp only when zero clamp method (or speed method with the clamp input allocated) is selected, request active and reference below level.
// - The clamp level accepts 0 to 10000 rpm and resets to 10 rpm.
// - A clamp level above the motor maximum speed is replaced by the motor maximum speed.
// - With the dedicated clamp input allocated, clamp also applies under plain speed control.
module zcs_zero_clamp_speed_control (
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   input  wire logic                       clk_en,
   input  wire logic [3:0]                 control_method_select,
   input  wire logic                       zero_clamp_allocated,
   input  wire logic                       zero_clamp_request_input_n,
   input  wire logic [15:0]                speed_reference,
   input  wire logic [15:0]                clamp_speed_level,
   input  wire logic                       clamp_level_load,
   input  wire logic [15:0]                motor_max_speed,
   output logic                            clamp_active,
   output logic [15:0]                     speed_command,
   output logic [15:0]                     effective_level
);

   // All registered state of the block
   typedef struct packed {
      logic                    req_meta;
      logic                    req_sync;
      logic [15:0]             level;
      logic [15:0]             eff_level;
      zcs_pkg::zcs_state_e     state;
      logic                    clamp;
      logic [15:0]             speed_cmd;
   } zcs_regs_s;

   // Values after reset
   localparam zcs_regs_s REGS_RESET = '{
      req_meta:  1'b0,
      req_sync:  1'b0,
      level:     zcs_pkg::LEVEL_RESET,
      eff_level: zcs_pkg::LEVEL_RESET,
      state:     zcs_pkg::ZCS_TRACK,
      clamp:     1'b0,
      speed_cmd: zcs_pkg::CMD_RESET
   };

   zcs_regs_s           r;
   zcs_regs_s           next_r;

   // Request path
   logic                req_level;
   logic                request_on;

   // Level path
   logic                level_in_range;
   logic                level_accept;
   logic [15:0]         level_value;
   logic                level_over_max;
   logic [15:0]         capped_level;

   // Method decode
   logic                method_is_zero_clamp_request_input;
   logic                method_is_speed;
   logic                alloc_override;
   logic                method_ok;

   // Decision
   logic                below;
   logic                clamp_cond;
   zcs_pkg::zcs_state_e next_state;
   logic [15:0]         next_cmd;

   always_comb begin
      next_r           = r;
      req_level        = 1'b0;
      request_on       = 1'b0;
      level_in_range   = 1'b0;
      level_accept     = 1'b0;
      level_value      = r.level;
      level_over_max   = 1'b0;
      capped_level     = r.level;
      method_is_zero_clamp_request_input = 1'b0;
      method_is_speed  = 1'b0;
      alloc_override   = 1'b0;
      method_ok        = 1'b0;
      below            = 1'b0;
      clamp_cond       = 1'b0;
      next_state       = zcs_pkg::ZCS_TRACK;
      next_cmd         = speed_reference;

      // Pin passes two flops, a low level is a request
      req_level        = ~zero_clamp_request_input_n;
      next_r.req_meta  = req_level;
      next_r.req_sync  = r.req_meta;
      if (r.req_sync) begin
         request_on = 1'b1;
      end else begin
         request_on = 1'b0;
      end

      // Level load, out of range values are dropped silently
      if (clamp_speed_level <= zcs_pkg::LEVEL_MAX) begin
         level_in_range = 1'b1;
      end else begin
         level_in_range = 1'b0;
      end
      level_accept = clamp_level_load && level_in_range;
      if (level_accept) begin
         level_value = clamp_speed_level;
      end else begin
         level_value = r.level;
      end
      next_r.level = level_value;

      // Threshold limited to the motor maximum
      if (r.level > motor_max_speed) begin
         level_over_max = 1'b1;
      end else begin
         level_over_max = 1'b0;
      end
      if (level_over_max) begin
         capped_level = motor_max_speed;
      end else begin
         capped_level = r.level;
      end
      next_r.eff_level = capped_level;

      // Method decode
      if (control_method_select == zcs_pkg::METHOD_ZERO_CLAMP_REQUEST_INPUT) begin
         method_is_zero_clamp_request_input = 1'b1;
      end else begin
         method_is_zero_clamp_request_input = 1'b0;
      end
      if (control_method_select == zcs_pkg::METHOD_SPEED) begin
         method_is_speed = 1'b1;
      end else begin
         method_is_speed = 1'b0;
      end
      alloc_override = zero_clamp_allocated && method_is_speed;
      method_ok      = method_is_zero_clamp_request_input || alloc_override;

      // Reference must be strictly below the threshold
      if (speed_reference < r.eff_level) begin
         below = 1'b1;
      end else begin
         below = 1'b0;
      end
      clamp_cond = method_ok && request_on && below;

      // Decision is taken afresh every cycle
      unique case (r.state)
         zcs_pkg::ZCS_TRACK: begin
            if (clamp_cond) begin
               next_state = zcs_pkg::ZCS_CLAMP;
            end else begin
               next_state = zcs_pkg::ZCS_TRACK;
            end
         end
         zcs_pkg::ZCS_CLAMP: begin
            if (clamp_cond) begin
               next_state = zcs_pkg::ZCS_CLAMP;
            end else begin
               next_state = zcs_pkg::ZCS_TRACK;
            end
         end
      endcase

      // Command follows the next state
      unique case (next_state)
         zcs_pkg::ZCS_CLAMP: begin
            next_cmd = zcs_pkg::SPEED_ZERO;
         end
         zcs_pkg::ZCS_TRACK: begin
            next_cmd = speed_reference;
         end
      endcase

      next_r.state     = next_state;
      next_r.speed_cmd = next_cmd;
      if (next_state == zcs_pkg::ZCS_CLAMP) begin
         next_r.clamp = 1'b1;
      end else begin
         next_r.clamp = 1'b0;
      end
   end

   // Clock enable low holds every flop
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= REGS_RESET;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // Outputs straight from flops
   assign clamp_active    = r.clamp;
   assign speed_command   = r.speed_cmd;
   assign effective_level = r.eff_level;

endmodule // zcs_zero_clamp_speed_control

//--- zcs_pkg.sv
package zcs_pkg;
   // Speed values in rpm, unsigned 16 bit
   localparam int unsigned SPEED_W          = 16;
   localparam logic [15:0] LEVEL_MAX        = 16'h2710;  // 10000 rpm
   localparam logic [15:0] LEVEL_RESET      = 16'h000a;  // 10 rpm
   localparam logic [15:0] MOTOR_MAX_RESET  = 16'h1770;  // 6000 rpm, plain default
   localparam logic [15:0] SPEED_ZERO       = 16'h0000;
   localparam logic [15:0] CMD_RESET        = 16'h0000;
   // Control method field codes
   localparam int unsigned METHOD_W         = 4;
   localparam logic [3:0]  METHOD_SPEED     = 4'h0;
   localparam logic [3:0]  METHOD_ZERO_CLAMP_REQUEST_INPUT    = 4'ha;

   typedef enum logic [1:0] {
      ZCS_TRACK = 2'b01,
      ZCS_CLAMP = 2'b10
   } zcs_state_e;
endpackage

//--- zcs_sva.sv
`timescale 1ns/10ps
module zcs_sva (input wire logic mclk, resetn, clk_en, zero_clamp_allocated,
   input wire logic zero_clamp_request_input_n, clamp_active,
   input wire logic [3:0] control_method_select,
   input wire logic [15:0] speed_reference, speed_command, effective_level, motor_max_speed);
   wire logic e = clk_en, n = zero_clamp_request_input_n, c = clamp_active;
   wire logic [3:0] m = control_method_select;
   wire logic [15:0] r = speed_reference, l = effective_level;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_off; e && n ##1 e[*2] |=> !c; endproperty
   a_off: assert property (p_off) else $error("clamp while idle");
   property p_on; (e && !n && m == 4'ha && r < l)[*4] |=> c; endproperty
   a_on: assert property (p_on) else $error("no clamp");
   property p_zero; c |-> speed_command == 16'h0000; endproperty
   a_zero: assert property (p_zero) else $error("command not zero");
   property p_trk; e ##1 !c |-> speed_command == $past(r); endproperty
   a_trk: assert property (p_trk) else $error("no tracking");
   property p_rel; e && r >= l |=> !c; endproperty
   a_rel: assert property (p_rel) else $error("no release");
   property p_meth; e && m != 4'ha && !(zero_clamp_allocated && m == 4'h0) |=> !c; endproperty
   a_meth: assert property (p_meth) else $error("wrong method");
   property p_cap; e |=> l <= $past(motor_max_speed) && l <= 16'h2710; endproperty
   a_cap: assert property (p_cap) else $error("level cap");
   c_on: cover property (e && c);
   c_off: cover property ($fell(c));
   c_alc: cover property (zero_clamp_allocated && m == 4'h0 && c);
endmodule // zcs_sva
bind zcs_zero_clamp_speed_control zcs_sva u_sva (.*);

//--- zcs_host.sv
`timescale 1ns/10ps
module zcs_host (input wire logic mclk, req, output logic pin_n);
   initial pin_n = 1'b1;
   always @(negedge mclk) pin_n <= !req;
endmodule // zcs_host

//--- zcs_zero_clamp_speed_control_tb.sv
`timescale 1ns/10ps
module zcs_zero_clamp_speed_control_tb;
   logic mclk = 0, resetn = 0, ld = 0, al = 0, rq = 0, ca, pn;
   logic en = 1;
   logic [3:0] m = 0;
   logic [15:0] r = 0, lv = 0, mx = 16'h1770, sc, el;
   logic [23:0] t [6] = '{24'ha60005, 24'ha4000a, 24'ha00005, 24'h0e0005, 24'h040005, 24'h3c0005};
   int err_count = 0, tests_run = 0;
   zcs_host u_host (.mclk(mclk), .req(rq), .pin_n(pn));
   zcs_zero_clamp_speed_control dut (.mclk(mclk), .resetn(resetn), .clk_en(en),
      .control_method_select(m), .zero_clamp_allocated(al), .zero_clamp_request_input_n(pn),
      .speed_reference(r), .clamp_speed_level(lv), .clamp_level_load(ld), .motor_max_speed(mx),
      .clamp_active(ca), .speed_command(sc), .effective_level(el));
   task automatic chk(logic [15:0] g, x);
      tests_run++;
      if (g !== x) begin err_count++; $display("ERROR %0t %h %h", $time, g, x); end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic load(logic [15:0] v);
      lv = v; ld = 1; @(negedge mclk); ld = 0; repeat (3) @(negedge mclk);
   endtask
   initial forever #2.5 mclk = ~mclk;
   initial begin #5000 err_count++; final_report; end
   initial begin
      repeat (8) @(negedge mclk); resetn = 1;
      chk(el, 16'h000a);
      foreach (t[i]) begin
         {m, al, rq} = t[i][23:18]; r = t[i][15:0]; repeat (5) @(negedge mclk);
         chk(ca, t[i][17]);
         chk(sc, t[i][17] ? 16'h0000 : r);
         $display("row %0d done", i);
      end
      load(16'h4e20); chk(el, 16'h000a);
      load(16'h2328); chk(el, mx);
      mx = 16'h2710; repeat (3) @(negedge mclk);
      chk(el, 16'h2328);
      $display("level done");
      {m, al, rq} = 6'h29; r = 16'h0005; repeat (5) @(negedge mclk);
      chk(ca, 16'h0001);
      en = 0; rq = 0; repeat (6) @(negedge mclk);
      chk(ca, 16'h0001);
      en = 1; repeat (5) @(negedge mclk);
      chk(ca, 16'h0000);
      $display("enable done");
      rq = 1; repeat (5) @(negedge mclk);
      chk(ca, 16'h0001);
      resetn = 0; @(negedge mclk); resetn = 1;
      chk(ca, 16'h0000);
      chk(sc, 16'h0000);
      chk(el, 16'h000a);
      @(negedge mclk); chk(sc, 16'h0005);
      $display("reset done");
      final_report;
   end
endmodule // zcs_zero_clamp_speed_control_tb
